// File: ebs_far_model.sv
// Far-side model: strobe recorder, wait source and bus master
`timescale 1ns/10ps
module ebs_far_model (
  input wire logic clock,
  input wire ebs_pkg::ebs_pins_s pins,
  input wire logic clr,
  input wire logic hold_on,
  input wire logic [7:0] wait_len,
  output logic hold_req_n,
  output logic wait_n,
  output logic [3:0] seen
);
  logic [7:0] wait_q;
  logic any_low;
  assign hold_req_n = !hold_on;
  assign wait_n = (wait_q == 8'h00);
  assign any_low = !(pins.rd_n & pins.low_lane_store_strobe & pins.high_lane_store_strobe);
  // Strobe capture record; wait starts on first low of read or either lane pin
  always_ff @(posedge clock) begin
    if (clr) begin
      seen <= 4'h0;
      wait_q <= 8'h00;
    end else begin
      seen <= seen | {pins.ale, !pins.rd_n, !pins.low_lane_store_strobe, !pins.high_lane_store_strobe};
      if (seen[2:0] == 3'h0 && any_low) begin
        wait_q <= wait_len;
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
endmodule : ebs_far_model

// File: ebs_pkg.sv
// Package for the external bus strobe and hold block
package ebs_pkg;
  // Strobe style select values
  localparam logic STYLE_SPLIT = 1'b0;
  localparam logic STYLE_SINGLE = 1'b1;
  // Data width select pin levels
  localparam logic WIDTH_16 = 1'b0;
  // Reset values and bus clock divider compare value
  localparam logic [1:0] BCLK_DIV_RST = 2'h0;
  localparam logic [1:0] BCLK_HALF = 2'h1;
  localparam logic RELEASE_ACK_RST = 1'b1;

  // Bus access request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic odd;
    logic word;
    logic [19:0] addr;
  } ebs_req_s;

  // Strobe pin group with one shared output enable
  typedef struct packed {
    logic rd_n;
    logic low_lane_store_strobe;
    logic high_lane_store_strobe;
    logic ale;
    logic oe;
  } ebs_pins_s;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_END, ST_HOLD} ebs_state_e;
endpackage : ebs_pkg

// File: ebs_strobes.sv
// External bus strobe generator with hold handshake and wait insertion
`timescale 1ns/10ps
// Functional notes
// - Split style, 16-bit bus: low-lane store strobe low writes even address
// - Split style: high-lane store strobe low writes odd address
// - Fetch strobe low reads external data in either style
// - Single style: single store strobe low writes data
// - Single style: upper-lane enable low on odd address access
// - Software setting selects split pair or single strobe with lane enable
// - Hold state kept while bus-release request input stays low
// - Release acknowledge low in hold state, high otherwise
// - Address-latch strobe output lets external logic capture address
// - Wait input low extends the current bus access
// - In hold, latch pin carries bus clock phase; strobes high-impedance
// - Data-width pin low selects 16-bit bus, high selects 8-bit
module ebs_strobes (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic strobe_style,
  input wire ebs_pkg::ebs_req_s req,
  output logic req_ready,
  output logic req_done,
  input wire logic hold_req_n,
  input wire logic wait_n,
  input wire logic width_sel,
  output logic bus_clk,
  output ebs_pkg::ebs_pins_s pins,
  output logic release_ack,
  output logic bus_16bit
);
  ebs_pkg::ebs_state_e state_q;
  logic [1:0] div_q;
  logic bclk_q;
  logic hold_s1_q, hold_s2_q, wait_s1_q, wait_s2_q, width_s1_q, width_s2_q;
  logic edge_w;
  logic write_q, odd_q, word_q;
  logic rd_q, wrl_q, wrh_q, ale_q, oe_q, ack_q, done_q;
  logic style_q;

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hold_s1_q <= 1'b1;
      hold_s2_q <= 1'b1;
      wait_s1_q <= 1'b1;
      wait_s2_q <= 1'b1;
      width_s1_q <= 1'b0;
      width_s2_q <= 1'b0;
    end else begin
      hold_s1_q <= hold_req_n;
      hold_s2_q <= hold_s1_q;
      wait_s1_q <= wait_n;
      wait_s2_q <= wait_s1_q;
      width_s1_q <= width_sel;
      width_s2_q <= width_s1_q;
    end
  end

  // Bus clock: divide by four; state only moves as it falls
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      div_q <= ebs_pkg::BCLK_DIV_RST;
      bclk_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      bclk_q <= (div_q == ebs_pkg::BCLK_HALF) || (div_q == 2'h2);
    end
  end
  assign edge_w = (div_q == 2'h3);
  assign bus_clk = bclk_q;

  // Strobe style captured per access so it cannot change mid-cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      style_q <= ebs_pkg::STYLE_SPLIT;
    end else if (state_q == ebs_pkg::ST_IDLE) begin
      style_q <= strobe_style;
    end
  end

  // Access sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= ebs_pkg::ST_IDLE;
      write_q <= 1'b0;
      odd_q <= 1'b0;
      word_q <= 1'b0;
    end else if (edge_w) begin
      unique case (state_q)
        ebs_pkg::ST_IDLE: begin
          // Hold has priority over new access
          if (!hold_s2_q) begin
            state_q <= ebs_pkg::ST_HOLD;
          end else if (req.valid) begin
            write_q <= req.write;
            odd_q <= req.odd;
            word_q <= req.word;
            state_q <= ebs_pkg::ST_ADDR;
          end
        end
        ebs_pkg::ST_ADDR: state_q <= ebs_pkg::ST_STROBE;
        ebs_pkg::ST_STROBE: begin
          if (wait_s2_q) begin
            state_q <= ebs_pkg::ST_END;
          end
        end
        ebs_pkg::ST_END: state_q <= ebs_pkg::ST_IDLE;
        ebs_pkg::ST_HOLD: begin
          if (hold_s2_q) begin
            state_q <= ebs_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign req_ready = edge_w && (state_q == ebs_pkg::ST_IDLE) && hold_s2_q;
  assign bus_16bit = (width_s2_q == ebs_pkg::WIDTH_16);

  // Strobe registers update on bus clock edges only, done_q on every clock
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_q <= 1'b1;
      wrl_q <= 1'b1;
      wrh_q <= 1'b1;
      ale_q <= 1'b0;
      oe_q <= 1'b1;
      ack_q <= ebs_pkg::RELEASE_ACK_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= edge_w && (state_q == ebs_pkg::ST_END);
      if (edge_w) begin
        ale_q <= req_ready && req.valid;
        rd_q <= !(((state_q == ebs_pkg::ST_ADDR) || (state_q == ebs_pkg::ST_STROBE && !wait_s2_q)) && !write_q);
        if (style_q == ebs_pkg::STYLE_SPLIT) begin
          // Low lane on even byte or word on 16-bit bus
          wrl_q <= !(((state_q == ebs_pkg::ST_ADDR) || (state_q == ebs_pkg::ST_STROBE && !wait_s2_q))
                     && write_q && (!odd_q || (word_q && bus_16bit)));
          // High lane on odd byte or word on 16-bit bus
          wrh_q <= !(((state_q == ebs_pkg::ST_ADDR) || (state_q == ebs_pkg::ST_STROBE && !wait_s2_q))
                     && write_q && (odd_q || (word_q && bus_16bit)));
        end else begin
          wrl_q <= !(((state_q == ebs_pkg::ST_ADDR) || (state_q == ebs_pkg::ST_STROBE && !wait_s2_q)) && write_q);
          // Upper lane enable for odd address, held over access
          wrh_q <= !(((state_q == ebs_pkg::ST_IDLE && req_ready && req.valid && (req.odd || req.word))
                     || ((state_q == ebs_pkg::ST_ADDR || state_q == ebs_pkg::ST_STROBE) && (odd_q || word_q)))
                     && !(state_q == ebs_pkg::ST_STROBE && wait_s2_q));
        end
        // Acknowledge tracks hold entry and exit
        ack_q <= !((state_q == ebs_pkg::ST_IDLE && !hold_s2_q) || (state_q == ebs_pkg::ST_HOLD && !hold_s2_q));
        oe_q <= !((state_q == ebs_pkg::ST_IDLE && !hold_s2_q) || (state_q == ebs_pkg::ST_HOLD && !hold_s2_q));
      end
    end
  end

  // Latch pin follows bus clock in hold
  always_comb begin
    pins.rd_n = rd_q;
    pins.low_lane_store_strobe = wrl_q;
    pins.high_lane_store_strobe = wrh_q;
    pins.ale = (state_q == ebs_pkg::ST_HOLD) ? bclk_q : ale_q;
    pins.oe = oe_q;
  end
  assign release_ack = ack_q;
  assign req_done = done_q;

  // Assertions: ack and float change on the same edge as the state, so they use same-cycle implication

  ack_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_HOLD) |-> !release_ack
  ) else $error("ack not low in hold");

  ack_outside_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q != ebs_pkg::ST_HOLD) |-> release_ack
  ) else $error("ack low outside hold");

  hold_stay_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_HOLD && !hold_s2_q) |=> (state_q == ebs_pkg::ST_HOLD)
  ) else $error("left hold early");

  ready_refused_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!hold_s2_q || state_q != ebs_pkg::ST_IDLE) |-> !req_ready
  ) else $error("request taken while busy or held");

  hold_float_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_HOLD) |-> !pins.oe
  ) else $error("strobes driven in hold");

  oe_drive_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q != ebs_pkg::ST_HOLD) |-> pins.oe
  ) else $error("strobes floating outside hold");

  hold_ale_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_HOLD) |-> pins.ale == bus_clk
  ) else $error("latch pin not bus clock");

  wait_extend_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_STROBE && !wait_s2_q) |=> state_q == ebs_pkg::ST_STROBE
  ) else $error("wait ignored");

  wait_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_STROBE && !wait_s2_q && write_q) |=> (!wrl_q || !wrh_q)
  ) else $error("write strobe dropped during wait");

  edge_align_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $changed(rd_q) |-> $past(edge_w)
  ) else $error("strobe off bus clock edge");

  edge_wrl_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $changed(wrl_q) |-> $past(edge_w)
  ) else $error("low lane off bus clock edge");

  edge_wrh_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $changed(wrh_q) |-> $past(edge_w)
  ) else $error("high lane off bus clock edge");

  bclk_shape_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    edge_w |-> bus_clk ##1 !bus_clk
  ) else $error("step not at bus clock fall");

  edge_ale_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $changed(ale_q) |-> $past(edge_w)
  ) else $error("latch strobe off bus clock edge");

  ale_take_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (req_ready && req.valid) |=> ale_q
  ) else $error("no latch strobe for access");

  read_no_write_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !rd_q |-> wrl_q
  ) else $error("read and write together");

  read_phase_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !rd_q |-> (state_q == ebs_pkg::ST_STROBE) && !write_q
  ) else $error("read strobe outside read access");

  write_phase_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !wrl_q |-> (state_q == ebs_pkg::ST_STROBE) && write_q
  ) else $error("write strobe outside write access");

  lane_idle_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == ebs_pkg::ST_IDLE) |-> rd_q && wrl_q && wrh_q
  ) else $error("strobe low while idle");

  split_odd_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (style_q == ebs_pkg::STYLE_SPLIT && !wrh_q && !word_q) |-> odd_q
  ) else $error("high lane on even");

  split_even_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (style_q == ebs_pkg::STYLE_SPLIT && !wrl_q && !word_q) |-> !odd_q
  ) else $error("low lane on odd");

  single_odd_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (style_q == ebs_pkg::STYLE_SINGLE && !wrl_q && odd_q) |-> !wrh_q
  ) else $error("lane enable missing");

  // Scenario covers
  single_cov: cover property (@(posedge clock) disable iff (!rst_b) style_q == ebs_pkg::STYLE_SINGLE && !wrh_q);
  write_cov: cover property (@(posedge clock) disable iff (!rst_b) !wrl_q ##1 wrl_q);
  read_cov: cover property (@(posedge clock) disable iff (!rst_b) !rd_q ##1 rd_q);
  hold_cov: cover property (@(posedge clock) disable iff (!rst_b) !release_ack ##1 release_ack);
  wait_cov: cover property (@(posedge clock) disable iff (!rst_b) state_q == ebs_pkg::ST_STROBE && !wait_s2_q);
endmodule : ebs_strobes

// File: ebs_strobes_tb.sv
// Testbench for the external bus strobe block
`timescale 1ns/10ps
module ebs_strobes_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic strobe_style = ebs_pkg::STYLE_SPLIT;
  logic width_sel = ebs_pkg::WIDTH_16;
  ebs_pkg::ebs_req_s req = '0;
  logic req_ready, req_done, hold_req_n, wait_n, bus_clk, release_ack, bus_16bit;
  ebs_pkg::ebs_pins_s pins;
  logic clr = 1'b1;
  logic hold_on = 1'b0;
  logic [7:0] wait_len = 8'h00;
  logic [3:0] seen;
  int miscompares = 0;
  int check_count = 0;
  int n;
  int n0;
  // 10 MHz clock
  always #50 clock = ~clock;
  ebs_strobes i_dut (.clock(clock), .rst_b(rst_b), .strobe_style(strobe_style), .req(req),
    .req_ready(req_ready), .req_done(req_done), .hold_req_n(hold_req_n), .wait_n(wait_n),
    .width_sel(width_sel), .bus_clk(bus_clk), .pins(pins), .release_ack(release_ack), .bus_16bit(bus_16bit));
  ebs_far_model i_far (.clock(clock), .pins(pins), .clr(clr), .hold_on(hold_on), .wait_len(wait_len),
    .hold_req_n(hold_req_n), .wait_n(wait_n), .seen(seen));
  task automatic report_and_stop;
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  // One access, strobes seen are {ale, read, low lane, high lane}
  task automatic access(input logic sty, input logic wr, input logic odd, input logic wd, input logic [3:0] exp);
    @(negedge clock);
    strobe_style = sty;
    clr = 1'b0;
    req = '{valid: 1'b1, write: wr, odd: odd, word: wd, addr: {19'h00000, odd}};
    for (n = 0; req_ready !== 1'b1 && n < 40; n++) @(negedge clock);
    if (n >= 40) begin
      chk(1'b0, "request not taken");
      report_and_stop();
    end
    @(negedge clock);
    req.valid = 1'b0;
    for (n = 0; req_done !== 1'b1 && n < 400; n++) @(negedge clock);
    if (n >= 400) begin
      chk(1'b0, "access timeout");
      report_and_stop();
    end
    chk(seen === exp && n >= 12, "strobe set or length");
    clr = 1'b1;
  endtask : access
  // Hold entry, floating strobes, exit
  task automatic hold_test;
    @(negedge clock);
    hold_on = 1'b1;
    for (n = 0; release_ack !== 1'b0 && n < 40; n++) @(negedge clock);
    chk(release_ack === 1'b0, "hold not entered");
    if (n >= 40) begin
      report_and_stop();
    end
    repeat (12) begin
      @(negedge clock);
      chk(release_ack === 1'b0 && pins.oe === 1'b0 && req_ready === 1'b0, "hold state");
      chk(pins.ale === bus_clk, "latch clock in hold");
    end
    hold_on = 1'b0;
    for (n = 0; release_ack !== 1'b1 && n < 40; n++) @(negedge clock);
    chk(release_ack === 1'b1, "ack not released");
  endtask : hold_test
  // Width select follows pin after sync
  task automatic width_test;
    width_sel = 1'b1;
    repeat (5) @(negedge clock);
    chk(bus_16bit === 1'b0, "8-bit select");
    width_sel = ebs_pkg::WIDTH_16;
    repeat (5) @(negedge clock);
    chk(bus_16bit === 1'b1, "16-bit select");
  endtask : width_test
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    chk(release_ack === 1'b1 && pins.oe === 1'b1 && pins.rd_n === 1'b1, "reset levels");
    width_test();
    access(ebs_pkg::STYLE_SPLIT, 1'b1, 1'b0, 1'b0, 4'hA);
    n0 = n;
    access(ebs_pkg::STYLE_SPLIT, 1'b1, 1'b1, 1'b0, 4'h9);
    access(ebs_pkg::STYLE_SPLIT, 1'b0, 1'b0, 1'b0, 4'hC);
    access(ebs_pkg::STYLE_SPLIT, 1'b1, 1'b0, 1'b1, 4'hB);
    access(ebs_pkg::STYLE_SINGLE, 1'b1, 1'b1, 1'b0, 4'hB);
    access(ebs_pkg::STYLE_SINGLE, 1'b1, 1'b0, 1'b0, 4'hA);
    access(ebs_pkg::STYLE_SINGLE, 1'b0, 1'b1, 1'b0, 4'hD);
    // 8-bit bus: single style as intended, split word keeps high lane idle
    width_sel = 1'b1;
    repeat (5) @(negedge clock);
    access(ebs_pkg::STYLE_SINGLE, 1'b1, 1'b1, 1'b0, 4'hB);
    access(ebs_pkg::STYLE_SPLIT, 1'b1, 1'b0, 1'b1, 4'hA);
    width_sel = ebs_pkg::WIDTH_16;
    repeat (5) @(negedge clock);
    wait_len = 8'h14;
    access(ebs_pkg::STYLE_SPLIT, 1'b1, 1'b0, 1'b0, 4'hA);
    chk(n > n0 + 8, "wait not honoured");
    wait_len = 8'h00;
    hold_test();
    access(ebs_pkg::STYLE_SPLIT, 1'b0, 1'b1, 1'b0, 4'hC);
    report_and_stop();
  end
endmodule : ebs_strobes_tb
